//--- src/dps_formatter.v
/*
 * discrete pins, reset discrete, fault discrete and broadcast status words.
 * assumes ref_clk at 25 mhz, pins asynchronous (high = open circuit),
 * status inputs from logic on the same clock, a word transmitter that
 * takes a word on valid and ready and fans it out to every transmitter.
 */
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "dps_defines.vh"

module dps_formatter #(
   parameter        DUAL_ANT_CAPABLE = 1,
   parameter [7:0]  UTC_LABEL        = 8'h68,
   parameter [7:0]  DATE_LABEL       = 8'hb0,
   parameter [31:0] RESAMPLE_CYCLES  = `DPS_RESAMPLE_MS * `DPS_CLK_KHZ
) (
   input  wire        ref_clk,        // system clock
   input  wire        nrst,           // async reset, active low
   input  wire [1:0]  loc_pin,        // location select pins
   input  wire        gps_speed_pin,  // positioning receiver speed pin
   input  wire        ant_count_pin,  // antenna count pin
   input  wire        maint_speed_pin,// maintenance link speed pin
   input  wire        reset_pin_n,    // reset discrete, low = grounded
   input  wire [1:0]  tx_on_pin_n,    // transmitter on/off discretes
   input  wire        radio_off_pin,  // radio off discrete, high = off
   input  wire [1:0]  vswr_high,      // standing-wave ratio above 5
   input  wire        bs_connected,   // connected to a base station
   input  wire        signal_det,     // signal detected
   input  wire [4:0]  rx_active,      // gps, maint 1/2, comms 1/2 activity
   input  wire        bit_fault,      // serious self-test fault
   input  wire [31:0] rx1_word,       // receiver 1 word
   input  wire        rx1_valid,      // receiver 1 word strobe
   input  wire [7:0]  reg_addr,       // register address
   input  wire [31:0] reg_wdata,      // register write data
   input  wire        reg_wr,         // write strobe
   input  wire        reg_rd,         // read strobe
   output reg  [31:0] reg_rdata,      // read data, cycle after strobe
   output reg  [31:0] word_data,      // broadcast word
   output reg         word_valid,     // broadcast word valid
   input  wire        word_ready,     // transmitter takes the word
   output reg         fault_oe,       // grounds the fault discrete
   output reg         fault_out,      // fault discrete level, always 0
   output reg         unit_rst,       // hold the rest of the unit in reset
   output reg         mem_init,       // memory initialisation in progress
   output reg  [1:0]  location,       // installed location minus one
   output reg         gps_high_speed, // positioning receiver at high rate
   output reg         dual_ant_en,    // dual antennas in use
   output reg         maint_high_speed,// maintenance link at high rate
   output reg         rf_tx_en        // rf transmitter powered
);

   localparam ST_HOLD  = 4'b0001;
   localparam ST_INIT  = 4'b0010;
   localparam ST_LATCH = 4'b0100;
   localparam ST_RUN   = 4'b1000;
   localparam NPIN     = 9;

   // odd parity over the low 31 bits
   function par_odd;
      input [30:0] w;
      begin
         par_odd = ~(^w);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, accept once stages two and three agree
   wire [NPIN-1:0] pin_raw;
   reg  [NPIN-1:0] s1_q;
   reg  [NPIN-1:0] s2_q;
   reg  [NPIN-1:0] s3_q;
   reg  [NPIN-1:0] pin_q;
   integer         i;

   assign pin_raw = {radio_off_pin, tx_on_pin_n, reset_pin_n,
                     maint_speed_pin, ant_count_pin, gps_speed_pin, loc_pin};

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1_q  <= {NPIN{1'b1}};
         s2_q  <= {NPIN{1'b1}};
         s3_q  <= {NPIN{1'b1}};
         pin_q <= {NPIN{1'b1}};
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (i = 0; i < NPIN; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
               pin_q[i] <= s3_q[i];
            end
         end
      end
   end

   wire [4:0] cfg_now   = pin_q[4:0];   // loc1, loc2, gps, ant, maint
   wire       rst_open  = pin_q[5];
   wire [1:0] tx_on_n   = pin_q[7:6];
   wire       radio_off = pin_q[8];

   ////////////////////////////////////////////////////////////////////////
   // restart sequence
   reg [3:0]  state_q;
   reg [3:0]  state_d;
   reg [15:0] init_cnt_q;
   reg [4:0]  cfg_q;

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_HOLD: begin
            if (rst_open) begin
               state_d = ST_INIT;
            end
         end
         ST_INIT: begin
            if (init_cnt_q == `DPS_INIT_CYCLES - 16'h0001) begin
               state_d = ST_LATCH;
            end
         end
         ST_LATCH: begin
            state_d = ST_RUN;
         end
         ST_RUN: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_HOLD;
         end
      endcase
      if (!rst_open) begin
         state_d = ST_HOLD;
      end
   end

   // state, init counter and latched configuration
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q    <= ST_INIT;
         init_cnt_q <= 16'h0000;
         cfg_q      <= 5'h1f;
      end else begin
         state_q <= state_d;
         if (state_q == ST_INIT) begin
            init_cnt_q <= init_cnt_q + 16'h0001;
         end else begin
            init_cnt_q <= 16'h0000;
         end
         if (state_q == ST_LATCH) begin
            cfg_q <= cfg_now;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   reg [4:0]  ctrl_q;
   reg [7:0]  sal_q;
   reg [4:0]  intermit_q;
   reg [31:0] rs_cnt_q;
   reg [18:0] tod_q;
   reg [18:0] date_q;
   wire       running  = (state_q == ST_RUN);
   wire       fault_now = bit_fault | ctrl_q[`DPS_CTRL_SWFAULT];
   wire       rs_tick  = (rs_cnt_q == RESAMPLE_CYCLES - 32'h00000001);
   wire [4:0] rs_diff  = (cfg_now ^ cfg_q) & {5{running & rs_tick}};
   wire [4:0] w1c      = (reg_wr && reg_addr == `DPS_REG_INTERMIT) ?
                         reg_wdata[4:0] : 5'h00;

   // software writes and re-sample checks
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q     <= `DPS_CTRL_RST;
         sal_q      <= `DPS_ADDR_RST;
         intermit_q <= 5'h00;
         rs_cnt_q   <= 32'h00000000;
      end else begin
         if (reg_wr && reg_addr == `DPS_REG_CTRL) begin
            ctrl_q <= reg_wdata[4:0];
         end
         if (reg_wr && reg_addr == `DPS_REG_ADDR) begin
            sal_q <= reg_wdata[7:0];
         end
         if (!ctrl_q[`DPS_CTRL_RESAMPLE] || rs_tick) begin
            rs_cnt_q <= 32'h00000000;
         end else begin
            rs_cnt_q <= rs_cnt_q + 32'h00000001;
         end
         intermit_q <= (intermit_q & ~w1c) | rs_diff;
      end
   end

   // receiver 1: keep time-of-day and date fields
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tod_q  <= 19'h00000;
         date_q <= 19'h00000;
      end else if (state_q == ST_INIT) begin
         tod_q  <= 19'h00000;
         date_q <= 19'h00000;
      end else if (rx1_valid) begin
         if (rx1_word[7:0] == UTC_LABEL) begin
            tod_q <= rx1_word[28:10];
         end
         if (rx1_word[7:0] == DATE_LABEL) begin
            date_q <= rx1_word[28:10];
         end
      end
   end

   // read data, one cycle after the strobe; unmapped reads zero
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `DPS_REG_CTRL:     reg_rdata <= {27'h0000000, ctrl_q};
            `DPS_REG_ADDR:     reg_rdata <= {24'h000000, sal_q};
            `DPS_REG_STATUS:   reg_rdata <= {16'h0000, rf_tx_en,
                                             fault_oe, state_q, cfg_now,
                                             cfg_q};
            `DPS_REG_INTERMIT: reg_rdata <= {27'h0000000, intermit_q};
            `DPS_REG_TOD:      reg_rdata <= {13'h0000, tod_q};
            `DPS_REG_DATE:     reg_rdata <= {13'h0000, date_q};
            default:           reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // discrete outputs and configuration decode
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fault_oe         <= 1'b1;
         fault_out        <= 1'b0;
         unit_rst         <= 1'b1;
         mem_init         <= 1'b0;
         location         <= 2'h0;
         gps_high_speed   <= 1'b1;
         dual_ant_en      <= 1'b0;
         maint_high_speed <= 1'b1;
         rf_tx_en         <= 1'b0;
      end else begin
         fault_oe  <= (state_d != ST_RUN) | fault_now;
         fault_out <= 1'b0;
         unit_rst  <= (state_d == ST_HOLD);
         mem_init  <= (state_d == ST_INIT);
         location  <= {~cfg_q[0], ~cfg_q[1]};
         gps_high_speed   <= cfg_q[2];
         dual_ant_en      <= (DUAL_ANT_CAPABLE != 0) & ~cfg_q[3];
         maint_high_speed <= cfg_q[4];
         rf_tx_en <= ~tx_on_n[0] & ~tx_on_n[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // broadcast words
   reg        sel_stat_q;
   wire [1:0] ssm = fault_now ? `DPS_SSM_FAIL :
                    ctrl_q[`DPS_CTRL_SSM_HI:`DPS_CTRL_SSM_LO];
   wire [5:0] opt = ctrl_q[`DPS_CTRL_OPT172] ?
                    {(DUAL_ANT_CAPABLE != 0), rx_active} : 6'h00;
   wire [30:0] addr_w;
   wire [30:0] stat_w;

   // address word: label, address code, option flags, zero pad, ssm
   assign addr_w = {ssm, 7'h00, opt, sal_q, `DPS_LABEL_ADDR};

   // status word: label, pins grounded, fault, antennas, discretes, activity
   assign stat_w = {ssm,
                    rx_active,
                    7'h00,
                    ~signal_det,
                    ~bs_connected,
                    (tx_on_n != 2'h0),
                    radio_off,
                    vswr_high[1] & dual_ant_en,
                    vswr_high[0],
                    fault_now,
                    ~cfg_q[1], ~cfg_q[0],
                    `DPS_LABEL_STAT};

   // alternate the two words while running, one per handshake
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         word_data  <= 32'h00000000;
         word_valid <= 1'b0;
         sel_stat_q <= 1'b0;
      end else if (!running) begin
         word_valid <= 1'b0;
         sel_stat_q <= 1'b0;
      end else if (!word_valid || word_ready) begin
         word_valid <= 1'b1;
         sel_stat_q <= ~sel_stat_q;
         if (sel_stat_q) begin
            word_data <= {par_odd(stat_w), stat_w};
         end else begin
            word_data <= {par_odd(addr_w), addr_w};
         end
      end
   end

endmodule

//--- src/dps_defines.vh
/*
 * constants for the discrete pin and status word formatter:
 * register offsets, field positions, reset values, labels, timing counts.
 * assumes a 25 mhz ref_clk; included by its bare name.
 */
// Notes on behaviour
// - latch every configuration pin at power-up and on each leaving of reset
// - optional periodic re-sample; disagreement with latched value flags intermittence
// - two location pins: open/open 1, open/gnd 2, gnd/open 3, gnd/gnd 4
// - device stays in reset while the reset discrete is grounded
// - release of reset discrete starts full memory initialisation
// - positioning receiver high rate when speed pin open, low when grounded
// - grounded antenna pin means dual antennas, used only if supported
// - maintenance link low rate when pin grounded, high rate when open
// - fault discrete grounded on serious fault or grounded reset, else open
// - fault discrete never depends on transmitter on/off inputs
// - fault held grounded through restart, released once restart completes
// - receiver 1 words give time-of-day and date for later use
// - every transmitter sends the full set of broadcast words
// - sign-status bits 31:30 are 00 normal, 01 no data, 10 test, 11 fail
// - address word: label 172, address code 9-16, zeros 17-29, ssm, parity
// - option: address word bits 17-22 carry activity and dual-antenna flags
// - status word: label 270, bits 9-10 location pins grounded, bit 11 fault
// - bits 12-13 flag high standing-wave ratio; 13 zero without second antenna
// - bit 14 radio off, bit 15 transmission inhibited, from discrete inputs
// - bit 16 is 0 when connected to a base station, 1 otherwise
// - bit 17 is 0 when a signal is detected, 1 otherwise
// - bits 18-24 zero, bits 25-29 receiver input activity flags
// - rf transmitter enabled only while both on/off inputs are grounded
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH

// register offsets (byte addresses)
`define DPS_REG_CTRL     8'h00
`define DPS_REG_ADDR     8'h04
`define DPS_REG_STATUS   8'h08
`define DPS_REG_INTERMIT 8'h0c
`define DPS_REG_TOD      8'h10
`define DPS_REG_DATE     8'h14

// control register fields and reset value
`define DPS_CTRL_RESAMPLE 0
`define DPS_CTRL_OPT172   1
`define DPS_CTRL_SSM_LO   2
`define DPS_CTRL_SSM_HI   3
`define DPS_CTRL_SWFAULT  4
`define DPS_CTRL_RST      5'h00
`define DPS_ADDR_RST      8'h00

// sign-status codes
`define DPS_SSM_NORMAL 2'h0
`define DPS_SSM_NCD    2'h1
`define DPS_SSM_TEST   2'h2
`define DPS_SSM_FAIL   2'h3

// labels (octal 172, 270)
`define DPS_LABEL_ADDR 8'h7a
`define DPS_LABEL_STAT 8'hb8

// timing
`define DPS_CLK_KHZ       25000
`define DPS_INIT_CYCLES   16'h0100
`define DPS_RESAMPLE_MS   1000

`endif

//--- dv/dps_chk.sv
/* port assertions for the discrete pin and status word formatter.
   assumes a bind onto every dps_formatter, defines header on path. */
`timescale 1ns/10ps
`include "dps_defines.vh"
module dps_chk (
   input logic        ref_clk,     // clock
   input logic        nrst,        // async reset, low
   input logic        reset_pin_n, // reset discrete
   input logic [1:0]  tx_on_pin_n, // tx on/off discretes
   input logic        bit_fault,   // self-test fault
   input logic [31:0] word_data,   // broadcast word
   input logic        word_valid,  // word offered
   input logic        word_ready,  // word taken
   input logic        fault_oe,    // fault discrete grounded
   input logic        unit_rst,    // unit held in reset
   input logic        mem_init,    // memory init running
   input logic [1:0]  location,    // location minus one
   input logic        rf_tx_en     // rf transmitter on
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   // word kinds and long conditions
   sequence s_addr; word_valid && word_data[7:0] == `DPS_LABEL_ADDR; endsequence
   sequence s_stat; word_valid && word_data[7:0] == `DPS_LABEL_STAT; endsequence
   sequence s_grounded; !reset_pin_n [*8]; endsequence
   sequence s_tx_off; (tx_on_pin_n != 2'b00) [*8]; endsequence
   ////////////////////////////////////////////////////////////////////////
   property p_parity; word_valid |-> ^word_data; endproperty
   a_parity: assert property (p_parity)
      else $error("broadcast word parity even");
   property p_order; s_addr ##0 word_ready ##1 word_valid |-> s_stat; endproperty
   a_order: assert property (p_order)
      else $error("status word does not follow address word");
   property p_addr_pad; s_addr |-> word_data[28:22] == 7'h00; endproperty
   a_addr_pad: assert property (p_addr_pad)
      else $error("address word pad not zero");
   property p_stat_rsvd; s_stat |-> word_data[23:17] == 7'h00; endproperty
   a_stat_rsvd: assert property (p_stat_rsvd)
      else $error("status word reserved bits not zero");
   property p_stat_loc;
      s_stat |-> word_data[9:8] == {location[0], location[1]};
   endproperty
   a_stat_loc: assert property (p_stat_loc)
      else $error("status word location bits wrong");
   property p_ssm_fail;
      s_stat ##0 word_data[10] |-> word_data[30:29] == `DPS_SSM_FAIL;
   endproperty
   a_ssm_fail: assert property (p_ssm_fail)
      else $error("fault word without failure sign-status");
   property p_hold; s_grounded |-> unit_rst && fault_oe && !word_valid; endproperty
   a_hold: assert property (p_hold)
      else $error("unit not held while reset discrete grounded");
   property p_init; mem_init |-> fault_oe; endproperty
   a_init: assert property (p_init)
      else $error("fault discrete open during restart");
   property p_rf_off; s_tx_off |-> !rf_tx_en; endproperty
   a_rf_off: assert property (p_rf_off)
      else $error("rf transmitter on with an open on/off input");
   property p_indep;
      $changed(tx_on_pin_n) && !fault_oe && !bit_fault && reset_pin_n
         |=> !fault_oe;
   endproperty
   a_indep: assert property (p_indep)
      else $error("fault discrete followed tx on/off inputs");
endmodule

bind dps_formatter dps_chk u_dps_chk (
   .ref_clk(ref_clk), .nrst(nrst), .reset_pin_n(reset_pin_n),
   .tx_on_pin_n(tx_on_pin_n), .bit_fault(bit_fault),
   .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
   .fault_oe(fault_oe), .unit_rst(unit_rst), .mem_init(mem_init),
   .location(location), .rf_tx_en(rf_tx_en));

//--- dv/dps_sink.sv
/* word receiver standing for the avionics computers.
   assumes the formatter's valid/ready word handshake on ref_clk. */
`timescale 1ns/10ps
module dps_sink (
   input  logic        ref_clk,    // clock
   input  logic        nrst,       // async reset, low
   input  logic        word_valid, // word offered
   input  logic        slow,       // take one word in eight cycles
   output logic        word_ready, // word taken
   output logic [15:0] words       // words taken so far
);
   logic [2:0] ph_q;
   // ready every cycle, or stalling when slow
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ph_q <= 3'h0;
         word_ready <= 1'b0;
         words <= 16'h0;
      end else begin
         ph_q <= ph_q + 3'h1;
         word_ready <= !slow || ph_q == 3'h3;
         if (word_valid && word_ready)
            words <= words + 16'h1;
      end
   end
endmodule

//--- dv/testbench.sv
/* self-checking bench for dps_formatter with a word sink.
   assumes 25 mhz ref_clk and a short re-sample period. */
`timescale 1ns/10ps
`include "dps_defines.vh"
module testbench;
   logic ref_clk = 0, nrst = 0, gps_p, ant_p, mnt_p, rst_n, radio_off;
   logic bs, sig, bfault, rx1_valid, rd, wr, slow, rd_pend = 0;
   logic chk_on = 0, opt = 0, word_valid, word_ready, fault_oe, unit_rst;
   logic mem_init, gps_hs, dual_en, maint_hs, rf_tx_en;
   logic [1:0] loc_pin, tx_n, vswr, ssm_c = 0, location, loc_l = 2'b11;
   logic [4:0] rxa;
   logic [7:0] addr, sac = 0;
   logic [31:0] rx1_word, wdata, rdata, word_data, r, seed = 32'h166c4836;
   logic [31:0] expq[$];
   int err_count = 0, num_checks = 0, k;
   ////////////////////////////////////////////////////////////////////////
   always #20 ref_clk = ~ref_clk;
   dps_formatter #(.RESAMPLE_CYCLES(32'd50)) u_dps_formatter (
      .ref_clk(ref_clk), .nrst(nrst), .loc_pin(loc_pin),
      .gps_speed_pin(gps_p), .ant_count_pin(ant_p), .maint_speed_pin(mnt_p),
      .reset_pin_n(rst_n), .tx_on_pin_n(tx_n), .radio_off_pin(radio_off),
      .vswr_high(vswr), .bs_connected(bs), .signal_det(sig), .rx_active(rxa),
      .bit_fault(bfault), .rx1_word(rx1_word), .rx1_valid(rx1_valid),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .word_data(word_data), .word_valid(word_valid),
      .word_ready(word_ready), .fault_oe(fault_oe), .fault_out(),
      .unit_rst(unit_rst), .mem_init(mem_init), .location(location),
      .gps_high_speed(gps_hs), .dual_ant_en(dual_en),
      .maint_high_speed(maint_hs), .rf_tx_en(rf_tx_en));
   dps_sink u_dps_sink (.ref_clk(ref_clk), .nrst(nrst),
      .word_valid(word_valid), .slow(slow), .word_ready(word_ready),
      .words());
   ////////////////////////////////////////////////////////////////////////
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // expected word for the label seen, from bench state
   function logic [31:0] exp_word(input logic [7:0] lb);
      logic [30:0] w;
      logic [1:0]  s;
      s = bfault ? `DPS_SSM_FAIL : ssm_c;
      if (lb == `DPS_LABEL_ADDR)
         w = {s, 7'h0, opt, opt ? rxa : 5'h0, sac, lb};
      else
         w = {s, rxa, 7'h0, !sig, !bs, |tx_n, radio_off, vswr[1] & !ant_p,
              vswr[0], bfault, !loc_l[1], !loc_l[0], `DPS_LABEL_STAT};
      return {~^w, w};
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task complete_run();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      expq.push_back(e);
      @(posedge ref_clk);
      rd <= 1'b0;
   endtask
   task settle();
      chk_on = 0;
      cyc(12);
      chk_on = 1;
   endtask
   task wait_run();
      int i;
      for (i = 0; i < 600 && fault_oe !== 1'b0; i++) @(negedge ref_clk);
      if (i == 600) begin
         err_count++;
         complete_run();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watcher: read data and accepted words against the notes
   always @(negedge ref_clk) begin
      if (rd_pend && expq.size() > 0)
         chk("reg_rdata", expq.pop_front(), rdata);
      rd_pend = rd;
      if (chk_on && word_valid && word_ready)
         chk("word_data", exp_word(word_data[7:0]), word_data);
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {loc_pin, gps_p, ant_p, mnt_p, rst_n, tx_n, radio_off} = 9'h1ff;
      {vswr, bs, sig, rxa, bfault, rx1_valid, rd, wr, slow} = 0;
      {rx1_word, wdata, addr} = 0;
      cyc(2);
      nrst <= 1'b1;
      rd_reg(`DPS_REG_CTRL, 32'h0);
      rd_reg(`DPS_REG_ADDR, 32'h0);
      rd_reg(8'h18, 32'h0);
      wait_run();
      for (k = 0; k < 4; k++) begin
         loc_pin <= k[1:0];
         {gps_p, ant_p, mnt_p} <= {k[0], k[1], !k[0]};
         rst_n <= 1'b0;
         settle();
         chk("unit_rst", 1, unit_rst);
         chk("fault_oe", 1, fault_oe);
         rst_n <= 1'b1;
         loc_l = k[1:0]; // pins relatched on this restart
         cyc(8);
         chk("mem_init", 1, mem_init);
         chk("fault_oe", 1, fault_oe);
         wait_run();
         loc_pin <= ~k[1:0];
         cyc(10);
         chk("location", {30'h0, !k[0], !k[1]}, location);
         chk("gps_hs", k[0], gps_hs);
         chk("dual_en", !k[1], dual_en);
         chk("maint_hs", !k[0], maint_hs);
         loc_pin <= k[1:0];
         chk_on = 0;
         r = rnd();
         {ssm_c, opt, sac} = {k[1:0], k[0], r[7:0]};
         wr_reg(`DPS_REG_CTRL, {28'h0, ssm_c, opt, 1'b0});
         wr_reg(`DPS_REG_ADDR, {24'h0, sac});
         rd_reg(`DPS_REG_ADDR, {24'h0, sac});
         r = rnd();
         {vswr, bs, sig, rxa, radio_off, tx_n} <= r[11:0];
         slow <= k[0];
         settle();
         cyc(40);
         chk("rf_tx_en", tx_n == 2'b00, rf_tx_en);
         r = rnd();
         rx1_word <= {r[31:8], k[0] ? 8'hb0 : 8'h68};
         rx1_valid <= 1'b1;
         cyc(1);
         rx1_valid <= 1'b0;
         rd_reg(k[0] ? `DPS_REG_DATE : `DPS_REG_TOD, rx1_word[28:10]);
      end
      bfault <= 1'b1;
      settle();
      chk("fault_oe", 1, fault_oe);
      cyc(30);
      bfault <= 1'b0;
      settle();
      tx_n <= ~tx_n;
      settle();
      chk("fault_oe", 0, fault_oe);
      chk_on = 0;
      wr_reg(`DPS_REG_CTRL, 32'h1);
      loc_pin[0] <= ~loc_pin[0];
      cyc(150);
      rd_reg(`DPS_REG_INTERMIT, 32'h1);
      loc_pin[0] <= ~loc_pin[0];
      cyc(10);
      wr_reg(`DPS_REG_INTERMIT, 32'h1f);
      rd_reg(`DPS_REG_INTERMIT, 32'h0);
      cyc(20);
      complete_run();
   end
endmodule
